// ---- rtl/smw_top.sv ----
// Purpose: standby pin gating and oscillator warm-up sequencing, APB controlled
// Assumes: clk_sys_i is the high-speed oscillator clock; pin inputs synchronous
// Notes: pin outputs and clock release are registered, one cycle behind inputs, except stop gating of pins, two cycles behind stop_enter_i
`timescale 1ns/1ps
module smw_top #(
  parameter int N_PINS = 8,
  parameter int ALE_PIN = 7,
  parameter logic [7:0] PULLUP_MASK = 8'h0F,
  parameter int WARM_SHORT_CYC = smw_pkg::SMW_WARM_SHORT_CYC,
  parameter int WARM_MID_CYC = smw_pkg::SMW_WARM_MID_CYC,
  parameter int WARM_LONG_CYC = smw_pkg::SMW_WARM_LONG_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // standby control
  input wire logic stop_enter_i,
  input wire logic sleep_enter_i,
  input wire logic slow_mode_i,
  input wire logic wake_req_i,
  output logic clk_run_o,
  output logic in_stop_o,
  output logic warm_done_o,
  // port pins
  input wire logic [N_PINS-1:0] port_direction_control_i,
  input wire logic [N_PINS-1:0] port_function_select_i,
  input wire logic [N_PINS-1:0] wake_func_en_i,
  input wire logic [N_PINS-1:0] port_data_i,
  output logic [N_PINS-1:0] pin_out_o,
  output logic [N_PINS-1:0] pin_oe_n_o,
  output logic [N_PINS-1:0] pin_in_en_o
);

  localparam logic [N_PINS-1:0] PU_MASK = PULLUP_MASK[N_PINS-1:0];
  localparam int CW = smw_pkg::SMW_CNT_W;

  // warm-up length per select code; code 00 is treated like the shortest
  function automatic logic [CW-1:0] warm_target(input logic [1:0] sel);
    logic [CW-1:0] t;
    t = CW'(WARM_SHORT_CYC);
    if (sel == smw_pkg::SMW_WSEL_MID) begin
      t = CW'(WARM_MID_CYC);
    end else if (sel == smw_pkg::SMW_WSEL_LONG) begin
      t = CW'(WARM_LONG_CYC);
    end
    return t;
  endfunction : warm_target

  function automatic logic reg_hit(input logic [11:0] a);
    return (a == smw_pkg::SMW_OFS_CTRL) || (a == smw_pkg::SMW_OFS_STAT);
  endfunction : reg_hit

  // register bus
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] stat_word;
  logic wr_fire;

  // standby sequencing
  smw_pkg::smw_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [1:0] wsel_q, wsel_d;
  logic slow_q, slow_d;
  logic clk_run_q, clk_run_d;
  logic in_stop_q, in_stop_d;
  logic done_q, done_d;

  // pins
  logic [N_PINS-1:0] out_q, out_d;
  logic [N_PINS-1:0] oe_n_q, oe_n_d;
  logic [N_PINS-1:0] in_en_q, in_en_d;

  logic [1:0] wsel_cfg;
  logic keep_cfg;
  logic ale_cfg;
  assign wsel_cfg = ctrl_q[smw_pkg::SMW_CTRL_WSEL_LSB +: 2];
  assign keep_cfg = ctrl_q[smw_pkg::SMW_CTRL_KEEP_BIT];
  assign ale_cfg = ctrl_q[smw_pkg::SMW_CTRL_ALE_BIT];
  assign wr_fire = psel_i && penable_i && pready_q && pwrite_i;

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[smw_pkg::SMW_STAT_STATE_LSB +: 2] = state_q;
    stat_word[smw_pkg::SMW_STAT_SLOW_BIT] = slow_q;
    stat_word[smw_pkg::SMW_STAT_WSEL_LSB +: 2] = wsel_q;
  end

  // answer in the first access cycle; pready drops after every completion
  always_comb begin
    ctrl_d = ctrl_q;
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    pready_d = 1'b0;
    if (psel_i && !penable_i) begin
      pready_d = 1'b1;
      pslverr_d = !reg_hit(paddr_i);
      prdata_d = 32'h0000_0000;
      if (!pwrite_i && paddr_i == smw_pkg::SMW_OFS_CTRL) begin
        prdata_d = ctrl_q;
      end else if (!pwrite_i && paddr_i == smw_pkg::SMW_OFS_STAT) begin
        prdata_d = stat_word;
      end
    end
    if (wr_fire && paddr_i == smw_pkg::SMW_OFS_CTRL && pstrb_i[0]) begin
      ctrl_d = pwdata_i & smw_pkg::SMW_CTRL_MASK;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= smw_pkg::SMW_CTRL_RESET;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    wsel_d = wsel_q;
    slow_d = slow_q;
    done_d = 1'b0;
    unique case (state_q)
      smw_pkg::SMW_RUN: begin
        slow_d = slow_mode_i;
        if (stop_enter_i) begin
          state_d = smw_pkg::SMW_STOP;
        end else if (sleep_enter_i) begin
          state_d = smw_pkg::SMW_SLEEP;
        end
      end
      smw_pkg::SMW_STOP, smw_pkg::SMW_SLEEP: begin
        if (wake_req_i) begin
          if (slow_q) begin
            state_d = smw_pkg::SMW_RUN;
            done_d = 1'b1;
          end else begin
            state_d = smw_pkg::SMW_WARM;
            cnt_d = smw_pkg::SMW_CNT_ZERO;
            wsel_d = wsel_cfg;
          end
        end
      end
      smw_pkg::SMW_WARM: begin
        if (cnt_q == warm_target(wsel_q) - smw_pkg::SMW_CNT_ONE) begin
          state_d = smw_pkg::SMW_RUN;
          done_d = 1'b1;
        end else begin
          cnt_d = cnt_q + smw_pkg::SMW_CNT_ONE;
        end
      end
    endcase
    clk_run_d = (state_d == smw_pkg::SMW_RUN);
    in_stop_d = (state_d == smw_pkg::SMW_STOP);
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= smw_pkg::SMW_RUN;
      cnt_q <= smw_pkg::SMW_CNT_ZERO;
      wsel_q <= 2'h0;
      slow_q <= 1'b0;
      clk_run_q <= 1'b1;
      in_stop_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      wsel_q <= wsel_d;
      slow_q <= slow_d;
      clk_run_q <= clk_run_d;
      in_stop_q <= in_stop_d;
      done_q <= done_d;
    end
  end

  // pin states follow the STOP state already registered
  always_comb begin
    out_d = port_data_i;
    oe_n_d = ~port_direction_control_i;
    in_en_d = ~port_direction_control_i;
    if (in_stop_q) begin
      if (keep_cfg) begin
        oe_n_d = ~port_direction_control_i;
        in_en_d = ~port_direction_control_i;
      end else begin
        oe_n_d = {N_PINS{1'b1}};
        in_en_d = port_function_select_i & ~port_direction_control_i;
        in_en_d = in_en_d | (wake_func_en_i & ~port_direction_control_i);
      end
      in_en_d = in_en_d & ~PU_MASK;
      if (ale_cfg) begin
        out_d[ALE_PIN] = 1'b0;
        oe_n_d[ALE_PIN] = 1'b0;
        in_en_d[ALE_PIN] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_q <= '0;
      oe_n_q <= '1;
      in_en_q <= '0;
    end else begin
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      in_en_q <= in_en_d;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign clk_run_o = clk_run_q;
  assign in_stop_o = in_stop_q;
  assign warm_done_o = done_q;
  assign pin_out_o = out_q;
  assign pin_oe_n_o = oe_n_q;
  assign pin_in_en_o = in_en_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sequence warm_start_s;
    (state_q != smw_pkg::SMW_WARM) ##1 (state_q == smw_pkg::SMW_WARM);
  endsequence
  sequence warm_end_s;
    (state_q == smw_pkg::SMW_WARM) ##1 (state_q == smw_pkg::SMW_RUN);
  endsequence

  warm_length_a: assert property (warm_end_s |->
      $past(cnt_q) == warm_target(wsel_q) - smw_pkg::SMW_CNT_ONE)
    else $error("warm-up ended at wrong count");
  warm_clear_a: assert property (warm_start_s |-> cnt_q == smw_pkg::SMW_CNT_ZERO)
    else $error("warm-up counter not cleared at wake");
  warm_count_a: assert property ((state_q == smw_pkg::SMW_WARM) ##1
      (state_q == smw_pkg::SMW_WARM) |-> cnt_q == $past(cnt_q) + smw_pkg::SMW_CNT_ONE)
    else $error("warm-up counter did not advance");
  resume_clock_a: assert property (warm_end_s |-> clk_run_o && warm_done_o)
    else $error("clock not restarted after warm-up");
  slow_skip_a: assert property (((state_q == smw_pkg::SMW_STOP) && slow_q
      && wake_req_i) |=> state_q == smw_pkg::SMW_RUN ##1 clk_run_o)
    else $error("slow return went through warm-up");
  stop_float_a: assert property ((in_stop_q && !keep_cfg && !ale_cfg) |=>
      &pin_oe_n_o)
    else $error("pin driven in stop without drive-keep");
  keep_drive_a: assert property ((in_stop_q && keep_cfg && !ale_cfg) |=>
      pin_oe_n_o == ~$past(port_direction_control_i))
    else $error("drive-keep did not hold outputs");
  ale_low_a: assert property ((in_stop_q && ale_cfg) |=>
      !pin_out_o[ALE_PIN] && !pin_oe_n_o[ALE_PIN])
    else $error("strobe pin not low in stop");
  pullup_off_a: assert property (in_stop_q |=> (pin_in_en_o & PU_MASK) == '0)
    else $error("pull-up pin input open in stop");
  wake_open_a: assert property ((in_stop_q && !keep_cfg && !ale_cfg) |=>
      (pin_in_en_o & ($past(wake_func_en_i) & ~$past(port_direction_control_i) & ~PU_MASK))
      == ($past(wake_func_en_i) & ~$past(port_direction_control_i) & ~PU_MASK))
    else $error("wake pin input closed in stop");
  fsel_open_a: assert property ((in_stop_q && !keep_cfg && !ale_cfg) |=>
      (pin_in_en_o & ($past(port_function_select_i) & ~$past(port_direction_control_i)
      & ~PU_MASK)) == ($past(port_function_select_i) & ~$past(port_direction_control_i)
      & ~PU_MASK))
    else $error("function-selected input closed in stop");

endmodule : smw_top

// ---- shared/smw_pkg.sv ----
// Purpose: shared constants of the stop-mode pin and warm-up controller
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: register offsets are byte addresses
package smw_pkg;
  // register map
  localparam logic [11:0] SMW_OFS_CTRL = 12'h000;
  localparam logic [11:0] SMW_OFS_STAT = 12'h004;
  // control word fields
  localparam int SMW_CTRL_WSEL_LSB = 0;
  localparam int SMW_CTRL_KEEP_BIT = 2;
  localparam int SMW_CTRL_ALE_BIT = 3;
  localparam logic [31:0] SMW_CTRL_RESET = 32'h0000_0002;
  localparam logic [31:0] SMW_CTRL_MASK = 32'h0000_000F;
  // status word fields
  localparam int SMW_STAT_STATE_LSB = 0;
  localparam int SMW_STAT_SLOW_BIT = 2;
  localparam int SMW_STAT_WSEL_LSB = 3;
  // warm-up select codes
  localparam logic [1:0] SMW_WSEL_SHORT = 2'h1;
  localparam logic [1:0] SMW_WSEL_MID = 2'h2;
  localparam logic [1:0] SMW_WSEL_LONG = 2'h3;
  // warm-up lengths in oscillator cycles
  localparam int SMW_WARM_SHORT_CYC = 256;
  localparam int SMW_WARM_MID_CYC = 16384;
  localparam int SMW_WARM_LONG_CYC = 65536;
  localparam int SMW_CNT_W = 17;
  localparam logic [SMW_CNT_W-1:0] SMW_CNT_ONE = 17'h0_0001;
  localparam logic [SMW_CNT_W-1:0] SMW_CNT_ZERO = 17'h0_0000;
  // standby state machine
  typedef enum logic [1:0] {
    SMW_RUN = 2'b00,
    SMW_STOP = 2'b01,
    SMW_SLEEP = 2'b10,
    SMW_WARM = 2'b11
  } smw_state_t;
endpackage : smw_pkg

// ---- tb/smw_top_tb_top.sv ----
// Purpose: self-checking bench of the standby pin and warm-up controller
// Assumes: warm-up lengths shortened to 8, 20 and 40 cycles
// Notes: expected pin shapes and warm-up lengths come from a bench model
`timescale 1ns/1ps
module smw_top_tb_top;
  localparam logic [7:0] PU = 8'h0F;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'hF;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, clk_run_o, in_stop_o, warm_done_o;
  logic stop_enter_i = 1'b0;
  logic sleep_enter_i = 1'b0;
  logic slow_mode_i = 1'b0;
  logic wake_req_i = 1'b0;
  logic [7:0] port_direction_control_i = 8'h0;
  logic [7:0] port_function_select_i = 8'h0;
  logic [7:0] wake_func_en_i = 8'h0;
  logic [7:0] port_data_i = 8'h0;
  logic [7:0] pin_out_o, pin_oe_n_o, pin_in_en_o;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;

  smw_top #(.WARM_SHORT_CYC(8), .WARM_MID_CYC(20), .WARM_LONG_CYC(40)) i_smw_top (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .stop_enter_i(stop_enter_i), .sleep_enter_i(sleep_enter_i), .slow_mode_i(slow_mode_i),
    .wake_req_i(wake_req_i), .clk_run_o(clk_run_o), .in_stop_o(in_stop_o),
    .warm_done_o(warm_done_o), .port_direction_control_i(port_direction_control_i),
    .port_function_select_i(port_function_select_i), .wake_func_en_i(wake_func_en_i),
    .port_data_i(port_data_i), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o),
    .pin_in_en_o(pin_in_en_o));

  always #50 clk_sys_i = ~clk_sys_i;

  task automatic complete_run;
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // bound on the whole run, far above the expected length
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    // no local limit: only the run bound ends a hung transfer
    do begin
      @(posedge clk_sys_i);
    end while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // idle edge, so a following call never reassigns psel in this step
    @(posedge clk_sys_i);
  endtask : apb

  // model of the pin shape: {out, oe_n, in_en}
  function automatic logic [23:0] pin_exp(input logic stp, input logic keep, input logic ale);
    logic [7:0] oe, ie, o;
    oe = ~port_direction_control_i;
    ie = ~port_direction_control_i;
    o = port_data_i;
    if (stp) begin
      if (!keep) begin
        oe = 8'hFF;
        ie = ie & (port_function_select_i | wake_func_en_i);
      end
      ie = ie & ~PU;
      if (ale) begin
        o[7] = 1'b0;
        oe[7] = 1'b0;
        ie[7] = 1'b0;
      end
    end
    return {o, oe, ie};
  endfunction : pin_exp

  task automatic chk_pins(input logic stp, input logic keep, input logic ale);
    logic [23:0] x;
    x = pin_exp(stp, keep, ale);
    chk("pin_oe_n", {24'h0, x[15:8]}, {24'h0, pin_oe_n_o});
    chk("pin_in_en", {24'h0, x[7:0]}, {24'h0, pin_in_en_o});
    chk("pin_out", {24'h0, x[23:16] & ~x[15:8]}, {24'h0, pin_out_o & ~x[15:8]});
  endtask : chk_pins

  initial begin
    logic [31:0] rd, ctrl;
    logic er, keep, ale, slp, slw;
    logic [1:0] sel;
    int n, t;
    rd = $urandom(32'h1B3D9811);
    repeat (10) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    apb(1'b0, smw_pkg::SMW_OFS_CTRL, 32'h0, rd, er);
    chk("ctrl reset", smw_pkg::SMW_CTRL_RESET, rd);
    chk("ctrl err", 32'h0, {31'h0, er});
    pstrb_i <= 4'hE;
    apb(1'b1, smw_pkg::SMW_OFS_CTRL, 32'h0000_000F, rd, er);
    pstrb_i <= 4'hF;
    apb(1'b1, smw_pkg::SMW_OFS_STAT, 32'hFFFF_FFFF, rd, er);
    apb(1'b0, smw_pkg::SMW_OFS_CTRL, 32'h0, rd, er);
    chk("ctrl lane0 off", smw_pkg::SMW_CTRL_RESET, rd);
    apb(1'b0, smw_pkg::SMW_OFS_STAT, 32'h0, rd, er);
    chk("stat read only", 32'h0, rd);
    apb(1'b1, 12'h008, 32'hFFFF_FFFF, rd, er);
    apb(1'b0, 12'h008, 32'h0, rd, er);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    for (int i = 0; i < 6; i++) begin
      sel = 2'((i % 3) + 1);
      keep = i[0];
      ale = i[1];
      slp = (i == 3);
      slw = (i == 5);
      ctrl = {28'h0, ale, keep, sel};
      apb(1'b1, smw_pkg::SMW_OFS_CTRL, ctrl | 32'hF0, rd, er);
      apb(1'b0, smw_pkg::SMW_OFS_CTRL, 32'h0, rd, er);
      chk("ctrl", ctrl, rd);
      port_direction_control_i <= 8'($urandom);
      port_function_select_i <= 8'($urandom);
      wake_func_en_i <= 8'($urandom);
      port_data_i <= 8'($urandom);
      slow_mode_i <= slw;
      repeat (3) @(posedge clk_sys_i);
      chk_pins(1'b0, keep, ale);
      stop_enter_i <= !slp;
      sleep_enter_i <= slp;
      @(posedge clk_sys_i);
      stop_enter_i <= 1'b0;
      sleep_enter_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      chk("in_stop", {31'h0, !slp}, {31'h0, in_stop_o});
      chk("clk_run", 32'h0, {31'h0, clk_run_o});
      chk_pins(!slp, keep, ale);
      apb(1'b0, smw_pkg::SMW_OFS_STAT, 32'h0, rd, er);
      chk("stat state", slp ? 32'h2 : 32'h1, {30'h0, rd[1:0]});
      chk("stat slow", {31'h0, slw}, {31'h0, rd[2]});
      t = (sel == 2'h1) ? 8 : (sel == 2'h2) ? 20 : 40;
      wake_req_i <= 1'b1;
      n = 0;
      // outputs read at the edge hold the value from the previous edge
      do begin
        @(posedge clk_sys_i);
        n++;
      end while (clk_run_o !== 1'b1 && n < 100);
      wake_req_i <= 1'b0;
      chk("warm cycles", slw ? 32'd2 : 32'(t + 2), 32'(n));
      chk("warm_done", 32'h1, {31'h0, warm_done_o});
      chk("in_stop off", 32'h0, {31'h0, in_stop_o});
      @(posedge clk_sys_i);
    end
    complete_run();
  end
endmodule : smw_top_tb_top
